// >>> verilog/aioc_map.vh
// constants for the actuator command and status block
`ifndef AIOC_MAP_VH
`define AIOC_MAP_VH
// clock and input filter timing
`define AIOC_CLK_MHZ 200
`define AIOC_FILT_MS 6
`define AIOC_FILT_CYC (`AIOC_FILT_MS * 1000 * `AIOC_CLK_MHZ)
// position and window widths
`define AIOC_POS_W 24
`define AIOC_WIN_DEF 24'h000032
// register offsets (byte addresses)
`define AIOC_REG_CTRL 8'h00
`define AIOC_REG_STAT 8'h04
`define AIOC_REG_WIN 8'h08
`define AIOC_REG_FWD_END 8'h0C
`define AIOC_REG_BWD_END 8'h10
`define AIOC_REG_POS 8'h14
`define AIOC_REG_ALARM 8'h18
// control register fields
`define AIOC_CTRL_INCR 0
`define AIOC_CTRL_PARCHG 1
`define AIOC_CTRL_SERVO 2
`define AIOC_CTRL_MPWR 3
`define AIOC_CTRL_HOMEDONE 4
`define AIOC_CTRL_ABSVAR 5
`define AIOC_CTRL_RESET 8'h09
// alarm register fields
`define AIOC_ALM_SET 0
`define AIOC_ALM_NOCLR 1
// motion states
`define AIOC_ST_IDLE 3'h0
`define AIOC_ST_HOME 3'h1
`define AIOC_ST_FWD 3'h2
`define AIOC_ST_BWD 3'h3
`define AIOC_ST_DECF 3'h4
`define AIOC_ST_DECB 3'h5
`endif

// >>> verilog/aioc_top.v
// actuator discrete command and status logic with wishbone registers
//
// Function
// - home return starts on command rise unhomed
// - command still on after homing: go forward
// - command dropped during homing: go backward
// - homed: forward when on, backward when off
// - keep moving until matching end reached
// - on-to-off during move: decelerate, reverse backward
// - off-to-on during move: decelerate, reverse forward
// - incremental sensor: unhomed after power restart
// - absolute sensor: tuning parameter change clears homed flag
// - alarm clear input clears active alarm
// - some alarms refuse clearing
// - brake released while release input held
// - auto release normally; engage servo/power off
// - end outputs on inside detection window
// - homed: end outputs follow position only
// - window half-width configurable, symmetric
// - absolute variant, motor power cut and servo off: ends off
// - press done output when pressing completes
// - press done off when no contact
// - alarm output low-active, on when normal
// - command and clear inputs filtered
`timescale 1ns/10ps
`default_nettype none
`include "aioc_map.vh"
module aioc_top (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // master device pins
   input wire direction_command_i,
   input wire alarm_clear_input_i,
   input wire brake_release_input_i,
   // motion core feedback
   input wire [23:0] position_i,
   input wire home_done_i,
   input wire decel_done_i,
   input wire press_mode_i,
   input wire press_done_i,
   input wire press_miss_i,
   // motion core commands
   output reg move_home_o,
   output reg move_fwd_o,
   output reg move_bwd_o,
   output reg decel_o,
   output reg brake_release_o,
   // status pins
   output reg rear_end_reached_o,
   output reg front_end_reached_o,
   output reg rear_press_done_o,
   output reg front_press_done_o,
   output reg alarm_ok_n_o
);
   parameter FILT_CYC = `AIOC_FILT_CYC;

   ////////////////////////////////////////////////////////////////////////////
   // reset release and input synchronisers
   reg [1:0] rst_sync_reg;
   wire rst_n = rst_sync_reg[1];
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   reg [2:0] pin_s1_reg;
   reg [2:0] pin_s2_reg;
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
      end else begin
         pin_s1_reg <= {brake_release_input_i, alarm_clear_input_i, direction_command_i};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input time-constant filters for command and alarm clear
   reg [31:0] dir_cnt_reg;
   reg [31:0] clr_cnt_reg;
   reg dir_reg;
   reg clr_reg;
   reg dir_prev_reg;
   reg clr_prev_reg;
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dir_cnt_reg <= 32'h0;
         clr_cnt_reg <= 32'h0;
         dir_reg <= 1'b0;
         clr_reg <= 1'b0;
         dir_prev_reg <= 1'b0;
         clr_prev_reg <= 1'b0;
      end else begin
         dir_prev_reg <= dir_reg;
         clr_prev_reg <= clr_reg;
         // level must stay stable FILT_CYC cycles to be taken
         if (pin_s2_reg[0] == dir_reg)
            dir_cnt_reg <= 32'h0;
         else if (dir_cnt_reg >= FILT_CYC - 1) begin
            dir_cnt_reg <= 32'h0;
            dir_reg <= pin_s2_reg[0];
         end else
            dir_cnt_reg <= dir_cnt_reg + 32'h1;
         if (pin_s2_reg[1] == clr_reg)
            clr_cnt_reg <= 32'h0;
         else if (clr_cnt_reg >= FILT_CYC - 1) begin
            clr_cnt_reg <= 32'h0;
            clr_reg <= pin_s2_reg[1];
         end else
            clr_cnt_reg <= clr_cnt_reg + 32'h1;
      end
   end
   wire dir_rise = dir_reg & ~dir_prev_reg;
   wire dir_fall = ~dir_reg & dir_prev_reg;
   wire clr_rise = clr_reg & ~clr_prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   reg [7:0] ctrl_reg;
   reg [23:0] win_reg;
   reg [23:0] fwd_end_reg;
   reg [23:0] bwd_end_reg;
   reg [1:0] alarm_reg;
   reg homed_reg;
   reg [2:0] state_reg;
   // a request is taken only while ack is low, so each bus cycle acks once
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i;

   // byte-lane merge of write data into a 24-bit field
   function [23:0] aioc_merge;
      input [23:0] old;
      input [31:0] dat;
      input [3:0] sel;
      begin
         aioc_merge = old;
         if (sel[0])
            aioc_merge[7:0] = dat[7:0];
         if (sel[1])
            aioc_merge[15:8] = dat[15:8];
         if (sel[2])
            aioc_merge[23:16] = dat[23:16];
      end
   endfunction

   // one-cycle ack, write on request cycle, unmapped reads zero
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl_reg <= `AIOC_CTRL_RESET;
         win_reg <= `AIOC_WIN_DEF;
         fwd_end_reg <= 24'h0;
         bwd_end_reg <= 24'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `AIOC_REG_CTRL: wb_dat_o <= {24'h0, ctrl_reg};
               `AIOC_REG_STAT: wb_dat_o <= {20'h0, homed_reg, state_reg, alarm_ok_n_o,
                  front_press_done_o, rear_press_done_o, front_end_reached_o,
                  rear_end_reached_o, brake_release_o, clr_reg, dir_reg};
               `AIOC_REG_WIN: wb_dat_o <= {8'h0, win_reg};
               `AIOC_REG_FWD_END: wb_dat_o <= {8'h0, fwd_end_reg};
               `AIOC_REG_BWD_END: wb_dat_o <= {8'h0, bwd_end_reg};
               `AIOC_REG_POS: wb_dat_o <= {8'h0, position_i};
               `AIOC_REG_ALARM: wb_dat_o <= {30'h0, alarm_reg};
               default: wb_dat_o <= 32'h0;
            endcase
         end
         if (wb_wr) begin
            case (wb_adr_i)
               `AIOC_REG_CTRL: if (wb_sel_i[0]) ctrl_reg <= wb_dat_i[7:0];
               `AIOC_REG_WIN: win_reg <= aioc_merge(win_reg, wb_dat_i, wb_sel_i);
               `AIOC_REG_FWD_END: fwd_end_reg <= aioc_merge(fwd_end_reg, wb_dat_i, wb_sel_i);
               `AIOC_REG_BWD_END: bwd_end_reg <= aioc_merge(bwd_end_reg, wb_dat_i, wb_sel_i);
               default: ;
            endcase
         end
      end
   end
   wire servo_on = ctrl_reg[`AIOC_CTRL_SERVO];
   wire mpwr_on = ctrl_reg[`AIOC_CTRL_MPWR];
   // parameter change and absolute reset strobes, decoded from control writes
   wire param_chg = wb_wr && (wb_adr_i == `AIOC_REG_CTRL) && wb_sel_i[0]
      && wb_dat_i[`AIOC_CTRL_PARCHG];
   wire home_set = wb_wr && (wb_adr_i == `AIOC_REG_CTRL) && wb_sel_i[0]
      && wb_dat_i[`AIOC_CTRL_HOMEDONE];

   ////////////////////////////////////////////////////////////////////////////
   // alarm state: software raises, clear input lowers unless locked
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n)
         alarm_reg <= 2'h0;
      else if (wb_wr && wb_adr_i == `AIOC_REG_ALARM && wb_sel_i[0])
         alarm_reg <= wb_dat_i[1:0]; // raise wins over a clear
      else if (clr_rise && !alarm_reg[`AIOC_ALM_NOCLR])
         alarm_reg <= 2'h0;
   end
   wire alarm = alarm_reg[`AIOC_ALM_SET];

   ////////////////////////////////////////////////////////////////////////////
   // homed flag; cleared at restart for incremental sensor
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n)
         homed_reg <= 1'b0;
      else if (state_reg == `AIOC_ST_HOME && home_done_i)
         homed_reg <= 1'b1;
      else if (param_chg && !ctrl_reg[`AIOC_CTRL_INCR])
         homed_reg <= 1'b0;
      else if (home_set && !ctrl_reg[`AIOC_CTRL_INCR])
         homed_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // window test: |pos - end| <= half-width
   function aioc_in_win;
      input [23:0] pos;
      input [23:0] endp;
      input [23:0] hw;
      begin
         // unsigned distance: subtract the smaller value from the larger
         if (pos >= endp)
            aioc_in_win = (pos - endp) <= hw;
         else
            aioc_in_win = (endp - pos) <= hw;
      end
   endfunction
   wire at_fwd = aioc_in_win(position_i, fwd_end_reg, win_reg);
   wire at_bwd = aioc_in_win(position_i, bwd_end_reg, win_reg);

   ////////////////////////////////////////////////////////////////////////////
   // motion state machine
   reg [2:0] state_next;
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `AIOC_ST_IDLE: begin
            if (alarm)
               state_next = `AIOC_ST_IDLE;
            else if (!homed_reg && dir_rise)
               state_next = `AIOC_ST_HOME;
            else if (homed_reg && dir_reg && !at_fwd)
               state_next = `AIOC_ST_FWD;
            else if (homed_reg && !dir_reg && !at_bwd)
               state_next = `AIOC_ST_BWD;
         end
         `AIOC_ST_HOME: begin
            if (home_done_i)
               state_next = dir_reg ? `AIOC_ST_FWD : `AIOC_ST_BWD;
         end
         `AIOC_ST_FWD: begin
            if (dir_fall)
               state_next = `AIOC_ST_DECB;
            else if (at_fwd)
               state_next = `AIOC_ST_IDLE;
         end
         `AIOC_ST_BWD: begin
            if (dir_rise)
               state_next = `AIOC_ST_DECF;
            else if (at_bwd)
               state_next = `AIOC_ST_IDLE;
         end
         `AIOC_ST_DECF: begin
            if (dir_fall)
               state_next = `AIOC_ST_DECB;
            else if (decel_done_i)
               state_next = `AIOC_ST_FWD;
         end
         `AIOC_ST_DECB: begin
            if (dir_rise)
               state_next = `AIOC_ST_DECF;
            else if (decel_done_i)
               state_next = `AIOC_ST_BWD;
         end
         default: state_next = `AIOC_ST_IDLE;
      endcase
      // an active alarm overrides every motion decision
      if (alarm)
         state_next = `AIOC_ST_IDLE;
   end

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n)
         state_reg <= `AIOC_ST_IDLE;
      else
         state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs, all but press done refreshed every cycle
   wire ends_ok = homed_reg && !(ctrl_reg[`AIOC_CTRL_ABSVAR] && !mpwr_on && !servo_on);
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         move_home_o <= 1'b0;
         move_fwd_o <= 1'b0;
         move_bwd_o <= 1'b0;
         decel_o <= 1'b0;
         brake_release_o <= 1'b0;
         rear_end_reached_o <= 1'b0;
         front_end_reached_o <= 1'b0;
         rear_press_done_o <= 1'b0;
         front_press_done_o <= 1'b0;
         alarm_ok_n_o <= 1'b1;
      end else begin
         move_home_o <= state_next == `AIOC_ST_HOME;
         move_fwd_o <= state_next == `AIOC_ST_FWD;
         move_bwd_o <= state_next == `AIOC_ST_BWD;
         decel_o <= state_next == `AIOC_ST_DECF || state_next == `AIOC_ST_DECB;
         // manual release, or auto release while servo and power on
         brake_release_o <= pin_s2_reg[2] || (servo_on && mpwr_on);
         // position only once homed, unless absolute variant with motor power and servo both off
         rear_end_reached_o <= ends_ok && at_bwd;
         front_end_reached_o <= ends_ok && at_fwd;
         // press done held until contact is missed or the motion state changes
         if (press_mode_i && press_done_i) begin
            rear_press_done_o <= state_reg == `AIOC_ST_BWD;
            front_press_done_o <= state_reg == `AIOC_ST_FWD;
         end else if (press_miss_i || state_next != state_reg) begin
            rear_press_done_o <= 1'b0;
            front_press_done_o <= 1'b0;
         end
         alarm_ok_n_o <= !alarm;
      end
   end
endmodule
`default_nettype wire

// >>> verif/aioc_checker.sv
// concurrent assertions watching the command and status block ports
`timescale 1ns/10ps
`default_nettype none
module aioc_checker #(parameter FILT_CYC = 8) (
   // clock, reset and bus
   input wire clk_i,
   input wire rst_n_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // motion feedback and pins in
   input wire decel_done_i,
   input wire press_miss_i,
   input wire brake_release_input_i,
   // motion commands and status out
   input wire move_home_o,
   input wire move_fwd_o,
   input wire move_bwd_o,
   input wire decel_o,
   input wire brake_release_o,
   input wire rear_press_done_o,
   input wire front_press_done_o,
   input wire alarm_ok_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // request not yet answered, and a manual release held past the sync stages
   sequence wb_req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence brk_held_s;
      brake_release_input_i [*4];
   endsequence
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property (wb_req_s |=> wb_ack_o)
      else $error("request not answered next cycle");
   rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   motion_onehot_a: assert property ($onehot0({move_home_o, move_fwd_o, move_bwd_o, decel_o}))
      else $error("motion commands overlap");
   fwd_no_flip_a: assert property (not (move_fwd_o ##1 move_bwd_o))
      else $error("reverse without deceleration");
   bwd_no_flip_a: assert property (not (move_bwd_o ##1 move_fwd_o))
      else $error("forward without deceleration");
   decel_hold_a: assert property (decel_o && !decel_done_i && alarm_ok_n_o |=> decel_o || !alarm_ok_n_o)
      else $error("deceleration left early");
   brake_hold_a: assert property (brk_held_s |-> brake_release_o)
      else $error("brake not released");
   press_miss_a: assert property (press_miss_i |-> ##[1:2] !(rear_press_done_o || front_press_done_o))
      else $error("press done kept after miss");
   alarm_stop_a: assert property ($fell(alarm_ok_n_o) |-> ##[0:2] !(move_fwd_o || move_bwd_o))
      else $error("motion kept during alarm");
endmodule
bind aioc_top aioc_checker #(.FILT_CYC(FILT_CYC)) chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .decel_done_i(decel_done_i), .press_miss_i(press_miss_i),
   .brake_release_input_i(brake_release_input_i), .move_home_o(move_home_o),
   .move_fwd_o(move_fwd_o), .move_bwd_o(move_bwd_o), .decel_o(decel_o),
   .brake_release_o(brake_release_o), .rear_press_done_o(rear_press_done_o),
   .front_press_done_o(front_press_done_o), .alarm_ok_n_o(alarm_ok_n_o));
`default_nettype wire

// >>> verif/aioc_plc_model.sv
// master device model driving the command pins
`timescale 1ns/10ps
`default_nettype none
module aioc_plc_model #(parameter int HOLD = 8) (
   // clock
   input wire clk_i,
   // command pins toward the block
   output logic dir_o,
   output logic clr_o,
   output logic brk_o
);
   // pins idle low from time zero
   initial begin
      dir_o = 1'b0;
      clr_o = 1'b0;
      brk_o = 1'b0;
   end
   // every level outlasts the sync stages and the input filter
   task automatic hold_lvl();
      repeat (HOLD + 4) @(posedge clk_i);
   endtask
   task automatic set_dir(input logic v);
      @(posedge clk_i);
      dir_o <= v;
      hold_lvl();
   endtask
   // after a stop with no end shown, head for the rear end first
   task automatic go_rear();
      set_dir(1'b0);
   endtask
   task automatic pulse_clr();
      @(posedge clk_i);
      clr_o <= 1'b1;
      hold_lvl();
      clr_o <= 1'b0;
      hold_lvl();
   endtask
   task automatic set_brk(input logic v);
      @(posedge clk_i);
      brk_o <= v;
   endtask
endmodule
`default_nettype wire

// >>> verif/actuator_io_command_status_test.sv
// self-checking bench for the actuator command and status block
`timescale 1ns/10ps
`default_nettype none
`include "aioc_map.vh"
module actuator_io_command_status_test;
   localparam int FILT = 8;
   localparam int HM = 0, FW = 1, BW = 2, DC = 3, BK = 4, RE = 5, FR = 6, RP = 7, FP = 8, AL = 9;
   localparam logic [23:0] FE = 24'h001000;
   localparam logic [23:0] BE = 24'h000100;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pmode = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, fb = 4'h0;
   logic [3:0] lanes = 4'hF;
   logic [31:0] rw;
   logic [31:0] wdat = 32'h0, q;
   logic [23:0] pos = 24'h000800;
   wire [31:0] rdat;
   wire [9:0] obs;
   wire ack, dir, clr, brk;
   int n_mismatch = 0, n_compared = 0, off;
   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;
   aioc_top #(.FILT_CYC(FILT)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .direction_command_i(dir), .alarm_clear_input_i(clr),
      .brake_release_input_i(brk), .position_i(pos), .home_done_i(fb[0]),
      .decel_done_i(fb[2]), .press_mode_i(pmode), .press_done_i(fb[1]), .press_miss_i(fb[3]),
      .move_home_o(obs[0]), .move_fwd_o(obs[1]), .move_bwd_o(obs[2]), .decel_o(obs[3]),
      .brake_release_o(obs[4]), .rear_end_reached_o(obs[5]), .front_end_reached_o(obs[6]),
      .rear_press_done_o(obs[7]), .front_press_done_o(obs[8]), .alarm_ok_n_o(obs[9]));
   aioc_plc_model #(.HOLD(FILT)) plc (.clk_i(clk_i), .dir_o(dir), .clr_o(clr), .brk_o(brk));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait for a status bit, a miss ends the run
   task automatic wait_bit(input int i, input logic v);
      int k;
      k = 0;
      while (obs[i] !== v && k < 200) begin
         @(posedge clk_i);
         k++;
      end
      chk({31'h0, obs[i]}, {31'h0, v});
      if (obs[i] !== v) final_report();
   endtask
   // one classic bus cycle, read data kept in q
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, lanes};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = rdat;
      {cyc, stb, we} <= 3'b000;
      chk({31'h0, ack}, 32'h1);
      if (ack !== 1'b1) final_report();
   endtask
   // one-cycle pulse on a motion feedback input
   task automatic kick(input int i);
      fb <= fb | (4'h1 << i);
      @(posedge clk_i);
      fb <= fb & ~(4'h1 << i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(40627));
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      wb(0, `AIOC_REG_CTRL, 32'h0); chk(q, 32'h9);
      wb(0, `AIOC_REG_WIN, 32'h0); chk(q, 32'h32);
      // random word through the low byte lane only, upper lanes must be ignored
      rw = $urandom;
      lanes = 4'h1;
      wb(1, `AIOC_REG_WIN, rw);
      lanes = 4'hF;
      wb(0, `AIOC_REG_WIN, 32'h0);
      chk(q, {24'h0, rw[7:0]});
      wb(1, `AIOC_REG_WIN, 32'h32);
      wb(0, 8'hFC, 32'h0); chk(q, 32'h0);
      wb(0, `AIOC_REG_STAT, 32'h0); chk({31'h0, q[11]}, 32'h0);
      wb(1, `AIOC_REG_FWD_END, {8'h00, FE});
      wb(1, `AIOC_REG_BWD_END, {8'h00, BE});
      plc.set_dir(1'b1); wait_bit(HM, 1);
      kick(0); wait_bit(FW, 1);
      pmode <= 1'b1; kick(1); wait_bit(FP, 1);
      kick(3); wait_bit(FP, 0);
      pmode <= 1'b0;
      plc.set_dir(1'b0); wait_bit(DC, 1); kick(2); wait_bit(BW, 1);
      plc.set_dir(1'b1); wait_bit(DC, 1); kick(2); wait_bit(FW, 1);
      pos <= FE + 24'h000005; wait_bit(FW, 0); wait_bit(FR, 1);
      plc.go_rear(); wait_bit(BW, 1);
      pmode <= 1'b1; kick(1); wait_bit(RP, 1);
      pmode <= 1'b0;
      pos <= BE; wait_bit(BW, 0); wait_bit(RE, 1);
      wait_bit(RP, 0);
      // random offsets around the rear end, servo off
      for (int i = 0; i < 12; i++) begin
         off = int'($urandom_range(200)) - 100;
         if (off == 50 || off == -50) off = 0;
         pos <= BE + 24'(off);
         repeat (6) @(posedge clk_i);
         chk({31'h0, obs[RE]}, {31'h0, off < 50 && off > -50});
      end
      pos <= BE;
      // switch to the absolute sensor first, then change a parameter
      wb(1, `AIOC_REG_CTRL, 32'h8);
      wb(1, `AIOC_REG_CTRL, 32'hA);
      wb(0, `AIOC_REG_STAT, 32'h0); chk({31'h0, q[11]}, 32'h0);
      pos <= 24'h000800;
      plc.set_dir(1'b1); wait_bit(HM, 1);
      plc.set_dir(1'b0); kick(0); wait_bit(BW, 1);
      pos <= BE; wait_bit(RE, 1);
      wb(1, `AIOC_REG_CTRL, 32'h20); wait_bit(RE, 0);
      wb(1, `AIOC_REG_CTRL, 32'h2C); wait_bit(RE, 1); wait_bit(BK, 1);
      wb(1, `AIOC_REG_CTRL, 32'h8); wait_bit(BK, 0);
      plc.set_brk(1'b1); wait_bit(BK, 1);
      plc.set_brk(1'b0); wait_bit(BK, 0);
      wb(1, `AIOC_REG_ALARM, 32'h1); wait_bit(AL, 0);
      plc.pulse_clr(); wait_bit(AL, 1);
      wb(1, `AIOC_REG_ALARM, 32'h3); plc.pulse_clr();
      chk({31'h0, obs[AL]}, 32'h0);
      // parameter change clears homed, absolute reset sets it again
      wb(1, `AIOC_REG_CTRL, 32'hA);
      wb(0, `AIOC_REG_STAT, 32'h0);
      chk({31'h0, q[11]}, 32'h0);
      wb(1, `AIOC_REG_CTRL, 32'h18);
      wb(0, `AIOC_REG_STAT, 32'h0);
      chk({31'h0, q[11]}, 32'h1);
      final_report();
   end
endmodule
`default_nettype wire
